// File: logic/swe_device.sv
/*
  device end: decodes serial frames, holds the array in flops, runs the
  self-timed erase/program cycle and reports ready/busy status.
  assumes link pins change synchronously to core_clk; serial clock edges
  are found by comparing with the previous sample.
*/
`timescale 1ns/10ps
`default_nettype none

module swe_device (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  swe_link_if.dev                         link,
  input  wire logic [swe_pkg::ADDR_W-1:0] rd_addr,
  output logic      [swe_pkg::DATA_W-1:0] rd_data,
  output logic                            unlocked,
  output logic                            busy
);

  localparam logic [swe_pkg::CNT_W-1:0] HDR_LAST  = swe_pkg::CNT_W'(swe_pkg::HDR_W - 1);
  localparam logic [swe_pkg::CNT_W-1:0] BODY_LAST = swe_pkg::CNT_W'(swe_pkg::BODY_W - 1);
  localparam logic [swe_pkg::TMR_W-1:0] T_PROG    = swe_pkg::TMR_W'(swe_pkg::PROG_CYC - 1);
  localparam logic [swe_pkg::TMR_W-1:0] T_FILL    = swe_pkg::TMR_W'(swe_pkg::FILL_CYC - 1);
  localparam logic [swe_pkg::WAIT_W-1:0] CSL_MIN  = swe_pkg::WAIT_W'(swe_pkg::CSL_CYC);

  swe_pkg::swe_dev_st_t           st_r;
  logic                           sel_q_r;
  logic                           sclk_q_r;
  logic [swe_pkg::BODY_W-1:0]     sh_r;
  logic [swe_pkg::BODY_W-1:0]     sh_nxt;
  logic [swe_pkg::CNT_W-1:0]      cnt_r;
  logic                           unlock_r;
  logic [swe_pkg::TMR_W-1:0]      tmr_r;
  logic [swe_pkg::WAIT_W-1:0]     low_r;
  logic                           pend_r;
  logic                           sdout_r;
  logic                           sdout_oe_r;
  logic [swe_pkg::DATA_W-1:0]     mem_r [swe_pkg::WORDS];
  logic [swe_pkg::DATA_W-1:0]     rd_r;

  // decoded fields and edges
  logic                           clk_rise;
  logic                           sel_fall;
  logic                           sel_rise;
  logic                           start_bit;
  logic [1:0]                     hdr_op;
  logic [1:0]                     hdr_sub;
  logic                           is_data_cmd;
  logic [1:0]                     arm_op;
  logic                           arm_fill;
  logic [swe_pkg::ADDR_W-1:0]     arm_addr;
  logic [swe_pkg::DATA_W-1:0]     arm_data;
  logic                           go;
  logic                           fin;

  assign clk_rise  = link.sclk & ~sclk_q_r;
  assign sel_fall  = sel_q_r & ~link.sel;
  assign sel_rise  = ~sel_q_r & link.sel;
  assign start_bit = (st_r == swe_pkg::D_IDLE) && clk_rise && link.sel && link.sdin;

  assign sh_nxt  = {sh_r[swe_pkg::BODY_W-2:0], link.sdin};
  assign hdr_op  = sh_nxt[swe_pkg::HDR_W-1 -: 2];
  assign hdr_sub = sh_nxt[swe_pkg::ADDR_W-1 -: 2];

  // write (01) or fill (00 with 01 prefix) carry a data word
  assign is_data_cmd = (hdr_op == swe_pkg::OP_WRITE) ||
                       (hdr_op == swe_pkg::OP_SHORT && hdr_sub == swe_pkg::SUB_FILL);

  assign arm_op   = sh_r[swe_pkg::BODY_W-1 -: 2];
  assign arm_fill = (arm_op == swe_pkg::OP_SHORT);
  assign arm_addr = sh_r[swe_pkg::DATA_W +: swe_pkg::ADDR_W];
  assign arm_data = sh_r[swe_pkg::DATA_W-1:0];

  // select fall after a full frame starts the cycle, only when unlocked
  assign go  = (st_r == swe_pkg::D_ARMED) && sel_fall && unlock_r;
  assign fin = (st_r == swe_pkg::D_BUSY) && (tmr_r == '0);

  assign unlocked      = unlock_r;
  assign busy          = (st_r == swe_pkg::D_BUSY);
  assign rd_data       = rd_r;
  assign link.sdout    = sdout_r;
  assign link.sdout_oe = sdout_oe_r;

  // pin history for edge detection
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_q_r  <= 1'b0;
      sclk_q_r <= 1'b0;
    end else begin
      sel_q_r  <= link.sel;
      sclk_q_r <= link.sclk;
    end
  end

  // frame decoder state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= swe_pkg::D_IDLE;
    end else begin
      unique case (st_r)
        swe_pkg::D_IDLE: begin
          if (start_bit) begin
            st_r <= swe_pkg::D_SHIFT;
          end
        end
        swe_pkg::D_SHIFT: begin
          if (!link.sel) begin
            st_r <= swe_pkg::D_IDLE; // short frame is dropped
          end else if (clk_rise && cnt_r == HDR_LAST && !is_data_cmd) begin
            st_r <= swe_pkg::D_SKIP;
          end else if (clk_rise && cnt_r == BODY_LAST) begin
            st_r <= swe_pkg::D_ARMED;
          end
        end
        swe_pkg::D_ARMED: begin
          if (go) begin
            st_r <= swe_pkg::D_BUSY;
          end else if (sel_fall) begin
            st_r <= swe_pkg::D_IDLE;
          end
        end
        swe_pkg::D_SKIP: begin
          if (!link.sel) begin
            st_r <= swe_pkg::D_IDLE;
          end
        end
        swe_pkg::D_BUSY: begin
          if (fin) begin
            st_r <= swe_pkg::D_IDLE;
          end
        end
      endcase
    end
  end

  // body shift register and bit counter, serial clock rising edges only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sh_r  <= '0;
      cnt_r <= '0;
    end else if (start_bit) begin
      sh_r  <= '0;
      cnt_r <= '0;
    end else if (st_r == swe_pkg::D_SHIFT && clk_rise) begin
      sh_r  <= sh_nxt;
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // programming lock; powers up locked
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      unlock_r <= 1'b0;
    end else if (st_r == swe_pkg::D_SHIFT && link.sel && clk_rise &&
                 cnt_r == HDR_LAST && hdr_op == swe_pkg::OP_SHORT) begin
      if (hdr_sub == swe_pkg::SUB_UNLK) begin
        unlock_r <= 1'b1;
      end else if (hdr_sub == swe_pkg::SUB_LOCK) begin
        unlock_r <= 1'b0;
      end
    end
  end

  // self-timed cycle counter; needs no serial clock once loaded
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_r <= '0;
    end else if (go) begin
      tmr_r <= arm_fill ? T_FILL : T_PROG;
    end else if (st_r == swe_pkg::D_BUSY && tmr_r != '0) begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  // array: erase at cycle start, program at cycle end
  for (genvar i = 0; i < swe_pkg::WORDS; i++) begin : g_word
    logic hit;
    assign hit = arm_fill || (arm_addr == swe_pkg::ADDR_W'(i));

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        mem_r[i] <= '1;
      end else if (go && hit) begin
        mem_r[i] <= '1;
      end else if (fin && hit) begin
        mem_r[i] <= arm_data;
      end
    end
  end

  // registered local read port for inspection by the owning system
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_r <= '0;
    end else begin
      rd_r <= mem_r[rd_addr];
    end
  end

  // select low time, saturating, for the status qualification
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_r <= '0;
    end else if (link.sel) begin
      low_r <= '0;
    end else if (low_r != CSL_MIN) begin
      low_r <= low_r + 1'b1;
    end
  end

  // status pending from cycle start until a select fall once ready
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 1'b0;
    end else if (go) begin
      pend_r <= 1'b1; // set wins over clear
    end else if (start_bit || (sel_fall && st_r != swe_pkg::D_BUSY)) begin
      pend_r <= 1'b0;
    end
  end

  // status driver: 0 while busy, 1 once done; released on select fall
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sdout_r    <= 1'b0;
      sdout_oe_r <= 1'b0;
    end else begin
      sdout_r <= (st_r != swe_pkg::D_BUSY);
      if (sel_fall || start_bit) begin
        sdout_oe_r <= 1'b0;
      end else if (sel_rise && pend_r && low_r == CSL_MIN) begin
        sdout_oe_r <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: logic/swe_host.sv
/*
  host end: turns user commands into serial frames and polls status after write and fill.
  assumes user request is held only while ready is high.
*/
`timescale 1ns/10ps
`default_nettype none

module swe_host (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  swe_link_if.host                        link,
  input  wire logic                       req,
  input  wire swe_pkg::swe_cmd_t          cmd,
  input  wire logic [swe_pkg::ADDR_W-1:0] addr,
  input  wire logic [swe_pkg::DATA_W-1:0] wdata,
  output logic                            ready,
  output logic                            done
);

  swe_pkg::swe_host_st_t               st_r;
  logic [swe_pkg::FRAME_W-1:0]         fr_r;
  logic [swe_pkg::CNT_W-1:0]           nbits_r;
  logic [swe_pkg::CNT_W-1:0]           bit_r;
  logic [swe_pkg::WAIT_W-1:0]          ph_r;
  logic [swe_pkg::WAIT_W-1:0]          wt_r;
  logic                                poll_r;
  logic                                sel_r;
  logic                                sclk_r;
  logic                                sdin_r;
  logic                                done_r;
  logic                                ph_end;
  logic [swe_pkg::FRAME_W-1:0]         frame;

  localparam logic [swe_pkg::WAIT_W-1:0] PH_LAST = swe_pkg::WAIT_W'(2 * swe_pkg::HALF_CYC - 1);
  localparam logic [swe_pkg::WAIT_W-1:0] PH_HALF = swe_pkg::WAIT_W'(swe_pkg::HALF_CYC);
  localparam logic [swe_pkg::WAIT_W-1:0] GAP_END = swe_pkg::WAIT_W'(swe_pkg::CSL_CYC + 1);
  localparam logic [swe_pkg::WAIT_W-1:0] POL_END = swe_pkg::WAIT_W'(swe_pkg::POLL_CYC);

  assign ph_end = (ph_r == PH_LAST);
  assign ready  = (st_r == swe_pkg::H_IDLE);
  assign done   = done_r;
  assign link.sel  = sel_r;
  assign link.sclk = sclk_r;
  assign link.sdin = sdin_r;

  // frame image, start bit first, left aligned
  always_comb begin
    unique case (cmd)
      swe_pkg::CMD_WRITE:  frame = {1'b1, swe_pkg::OP_WRITE, addr, wdata};
      swe_pkg::CMD_FILL:   frame = {1'b1, swe_pkg::OP_SHORT, swe_pkg::SUB_FILL,
                                    {(swe_pkg::ADDR_W-2){1'b0}}, wdata};
      swe_pkg::CMD_UNLOCK: frame = {1'b1, swe_pkg::OP_SHORT, swe_pkg::SUB_UNLK,
                                    {(swe_pkg::FRAME_W-5){1'b0}}};
      swe_pkg::CMD_LOCK:   frame = {1'b1, swe_pkg::OP_SHORT, swe_pkg::SUB_LOCK,
                                    {(swe_pkg::FRAME_W-5){1'b0}}};
    endcase
  end

  // sequencer: shift, gap, poll, final release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r    <= swe_pkg::H_IDLE;
      fr_r    <= '0;
      nbits_r <= '0;
      bit_r   <= '0;
      ph_r    <= '0;
      wt_r    <= '0;
      poll_r  <= 1'b0;
    end else begin
      unique case (st_r)
        swe_pkg::H_IDLE: if (req) begin
          st_r    <= swe_pkg::H_BIT;
          fr_r    <= frame;
          nbits_r <= (cmd == swe_pkg::CMD_WRITE || cmd == swe_pkg::CMD_FILL) ?
                     swe_pkg::CNT_W'(swe_pkg::FRAME_W) : swe_pkg::CNT_W'(1 + swe_pkg::HDR_W);
          poll_r  <= (cmd == swe_pkg::CMD_WRITE || cmd == swe_pkg::CMD_FILL);
          bit_r   <= '0;
          ph_r    <= '0;
        end
        swe_pkg::H_BIT: begin
          ph_r <= ph_end ? '0 : ph_r + 1'b1;
          if (ph_end) begin
            fr_r  <= {fr_r[swe_pkg::FRAME_W-2:0], 1'b0};
            bit_r <= bit_r + 1'b1;
            if (bit_r == nbits_r - 1'b1) begin
              st_r <= swe_pkg::H_GAP;
              wt_r <= '0;
            end
          end
        end
        swe_pkg::H_GAP: begin
          wt_r <= wt_r + 1'b1;
          if (wt_r == GAP_END) begin
            st_r <= poll_r ? swe_pkg::H_POLL : swe_pkg::H_IDLE;
            wt_r <= '0;
          end
        end
        swe_pkg::H_POLL: begin
          wt_r <= (wt_r == POL_END) ? wt_r : wt_r + 1'b1;
          if (wt_r == POL_END && link.sdout_line) begin
            st_r <= swe_pkg::H_END;
            wt_r <= '0;
          end
        end
        swe_pkg::H_END: begin
          wt_r <= wt_r + 1'b1;
          if (wt_r == GAP_END) begin
            st_r <= swe_pkg::H_IDLE;
          end
        end
      endcase
    end
  end

  // link pins from flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_r  <= 1'b0;
      sclk_r <= 1'b0;
      sdin_r <= 1'b0;
    end else begin
      sel_r  <= (st_r == swe_pkg::H_BIT) || (st_r == swe_pkg::H_POLL);
      sclk_r <= (st_r == swe_pkg::H_BIT) && (ph_r >= PH_HALF) && !ph_end;
      sdin_r <= (st_r == swe_pkg::H_BIT) && fr_r[swe_pkg::FRAME_W-1];
    end
  end

  // one-cycle completion pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= ((st_r == swe_pkg::H_GAP) && (wt_r == GAP_END) && !poll_r) ||
                ((st_r == swe_pkg::H_END) && (wt_r == GAP_END));
    end
  end

endmodule

`default_nettype wire

// File: logic/swe_link_if.sv
/*
  four-wire serial link between host and device.
  assumes the data output wire has a pull-up: released reads as one.
*/
`timescale 1ns/10ps
`default_nettype none

interface swe_link_if;
  logic sel;
  logic sclk;
  logic sdin;
  logic sdout;
  logic sdout_oe;
  logic sdout_line;

  // resolved level of the data output wire
  assign sdout_line = sdout_oe ? sdout : 1'b1;

  modport host (
    output sel,
    output sclk,
    output sdin,
    input  sdout_line
  );

  modport dev (
    input  sel,
    input  sclk,
    input  sdin,
    output sdout,
    output sdout_oe
  );
endinterface

`default_nettype wire

// File: logic/swe_pkg.sv
/*
  constants and types shared by both ends of the serial write engine link.
  assumes one core clock at 50 MHz on both ends; link pins are sampled
  as ordinary synchronous inputs.
*/
package swe_pkg;

  // organisation: 1 selects 16-bit words, 0 selects 8-bit bytes
  localparam bit          ORG16    = 1'b1;
  localparam int          DATA_W   = ORG16 ? 16 : 8;
  localparam int          ADDR_W   = ORG16 ? 6 : 7;
  localparam int          WORDS    = 1 << ADDR_W;
  localparam int          HDR_W    = 2 + ADDR_W;
  localparam int          BODY_W   = HDR_W + DATA_W;
  localparam int          FRAME_W  = 1 + BODY_W;
  localparam int          CNT_W    = 5;

  // opcodes and address-field prefixes of the short commands
  localparam logic [1:0]  OP_WRITE = 2'h1;
  localparam logic [1:0]  OP_SHORT = 2'h0;
  localparam logic [1:0]  SUB_FILL = 2'h1;
  localparam logic [1:0]  SUB_UNLK = 2'h3;
  localparam logic [1:0]  SUB_LOCK = 2'h0;

  // timing at 50 MHz
  localparam int          CLK_NS   = 20;
  localparam int          CSL_NS   = 250;
  localparam int          CSL_CYC  = (CSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PROG_NS  = 2000;
  localparam int          PROG_CYC = PROG_NS / CLK_NS;
  localparam int          FILL_NS  = 4000;
  localparam int          FILL_CYC = FILL_NS / CLK_NS;
  localparam int          TMR_W    = 8;
  localparam int          HALF_CYC = 4;
  localparam int          POLL_CYC = 4;
  localparam int          WAIT_W   = 5;

  typedef enum logic [1:0] {
    CMD_WRITE  = 2'h0,
    CMD_FILL   = 2'h1,
    CMD_UNLOCK = 2'h2,
    CMD_LOCK   = 2'h3
  } swe_cmd_t;

  typedef enum logic [4:0] {
    D_IDLE  = 5'h01,
    D_SHIFT = 5'h02,
    D_ARMED = 5'h04,
    D_SKIP  = 5'h08,
    D_BUSY  = 5'h10
  } swe_dev_st_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_BIT  = 5'h02,
    H_GAP  = 5'h04,
    H_POLL = 5'h08,
    H_END  = 5'h10
  } swe_host_st_t;

endpackage

// File: verif/swe_sva.sv
/*
  checker for the serial link between host and device ends.
  assumes it sits beside the link interface in the bench top.
*/
`timescale 1ns/10ps
`default_nettype none

module swe_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sel,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sdout,
  input wire logic sdout_oe,
  input wire logic sdout_line
);
  logic [4:0] rise_r;
  logic [4:0] low_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // clock rises within a frame
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rise_r <= 5'h00;
    else if (!sel) rise_r <= 5'h00;
    else if ($rose(sclk)) rise_r <= rise_r + 5'h01;
  end

  // cycles with select low, saturating; reset counts as a long low time
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) low_r <= 5'h1F;
    else if (sel) low_r <= 5'h00;
    else if (low_r != 5'h1F) low_r <= low_r + 5'h01;
  end

  sequence hi_three;
    sclk [*3] ##1 !sclk;
  endsequence

  sequence oe_drop;
    ##[1:3] !sdout_oe;
  endsequence

  sel_gap_a: assert property ($rose(sel) |-> low_r >= swe_pkg::CSL_CYC)
    else $error("select raised too soon");
  frame_len_a: assert property ($fell(sel) |-> (rise_r == 5'h00 ||
    rise_r == swe_pkg::HDR_W + 1 || rise_r == swe_pkg::FRAME_W))
    else $error("frame clock count wrong");
  start_bit_a: assert property ($rose(sclk) && rise_r == 5'h00 |-> sdin)
    else $error("first bit not a start bit");
  clk_pulse_a: assert property ($rose(sclk) |-> hi_three)
    else $error("serial clock pulse width wrong");
  clk_idle_a: assert property (!sel |-> !sclk)
    else $error("serial clock outside frame");
  din_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdin))
    else $error("data moved while clock high");
  oe_release_a: assert property ($fell(sel) |-> oe_drop)
    else $error("output not released");
  oe_idle_a: assert property (!sel && !$past(sel) && !$past(sel, 2) &&
    !$past(sel, 3) |-> !sdout_oe)
    else $error("output driven without select");
  oe_start_a: assert property ($rose(sdout_oe) |-> sel && $past(sel))
    else $error("status driven without select");
  ready_hold_a: assert property (sdout_oe && $past(sdout_oe) && $past(sdout) |->
    sdout_line)
    else $error("ready status dropped while driven");
endmodule

`default_nettype wire

// File: verif/tb_top.sv
/*
  bench for host and device ends joined by one link.
  assumes 50 MHz core clock and the package timing constants.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int P = swe_pkg::PROG_CYC;
  localparam int F = swe_pkg::FILL_CYC;
  typedef struct {
    swe_pkg::swe_cmd_t c;
    logic [5:0]        a;
    logic [15:0]       d;
    logic [15:0]       e;
    logic              u;
    int                n;
  } swe_row_t;
  logic                core_clk = 1'b0;
  logic                rstn = 1'b0;
  logic                req = 1'b0;
  swe_pkg::swe_cmd_t   cmd = swe_pkg::CMD_WRITE;
  logic [5:0]          addr = 6'h00;
  logic [15:0]         wdata = 16'h0000;
  logic [5:0]          rd_addr = 6'h00;
  logic [15:0]         rd_data;
  logic                ready;
  logic                done;
  logic                unlocked;
  logic                busy;
  logic [2:0]          busy_q = 3'h0;
  int                  busy_n = 0;
  int                  stat_n = 0;
  int                  clk_n = 0;
  int                  num_errors = 0;
  int                  comparisons = 0;
  swe_row_t rows [8] = '{
    '{swe_pkg::CMD_UNLOCK, 6'h00, 16'h0000, 16'hFFFF, 1'b1, 0},
    '{swe_pkg::CMD_WRITE, 6'h00, 16'h1234, 16'h1234, 1'b1, P},
    '{swe_pkg::CMD_WRITE, 6'h3F, 16'hABCD, 16'hABCD, 1'b1, P},
    '{swe_pkg::CMD_WRITE, 6'h3F, 16'h5A5A, 16'h5A5A, 1'b1, P},
    '{swe_pkg::CMD_FILL, 6'h05, 16'hC3C3, 16'hC3C3, 1'b1, F},
    '{swe_pkg::CMD_LOCK, 6'h05, 16'h0000, 16'hC3C3, 1'b0, 0},
    '{swe_pkg::CMD_WRITE, 6'h05, 16'h0F0F, 16'hC3C3, 1'b0, 0},
    '{swe_pkg::CMD_FILL, 6'h05, 16'h0000, 16'hC3C3, 1'b0, 0}};

  swe_link_if swe_link_if_inst ();

  swe_host swe_host_inst (
    .core_clk (core_clk), .rstn (rstn), .link (swe_link_if_inst.host),
    .req (req), .cmd (cmd), .addr (addr), .wdata (wdata),
    .ready (ready), .done (done));

  swe_device swe_device_inst (
    .core_clk (core_clk), .rstn (rstn), .link (swe_link_if_inst.dev),
    .rd_addr (rd_addr), .rd_data (rd_data), .unlocked (unlocked), .busy (busy));

  swe_sva swe_sva_inst (
    .core_clk (core_clk), .rstn (rstn), .sel (swe_link_if_inst.sel),
    .sclk (swe_link_if_inst.sclk), .sdin (swe_link_if_inst.sdin),
    .sdout (swe_link_if_inst.sdout), .sdout_oe (swe_link_if_inst.sdout_oe),
    .sdout_line (swe_link_if_inst.sdout_line));

  // clock generator
  always #10 core_clk = ~core_clk;

  task automatic check_bit(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s %h", $time, msg, got);
    end
  endtask

  task automatic check_cnt(input int got, input int exp, input string msg);
    comparisons++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %0t %s %0d", $time, msg, got);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // status polarity, erase-first and cycle counters
  always @(posedge core_clk) begin
    if (rstn && busy === 1'b1) busy_n++;
    if (rstn && busy === 1'b1 && swe_link_if_inst.sclk === 1'b1) clk_n++;
    if (rstn && swe_link_if_inst.sdout_oe === 1'b1) begin
      stat_n++;
      if (busy === 1'b1) check_bit(swe_link_if_inst.sdout_line, 1'b0, "busy status");
      else if (busy_q === 3'h0) check_bit(swe_link_if_inst.sdout_line, 1'b1, "ready");
    end
    if (busy === 1'b1 && busy_q[1:0] === 2'h3) check_word(rd_data, 16'hFFFF, "erase");
    busy_q = {busy_q[1:0], busy};
  end

  task automatic run_cmd(input swe_pkg::swe_cmd_t c, input logic [5:0] a,
                         input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= 1'b1;
    cmd <= c;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    req <= 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    check_bit(n < 3000, 1'b1, "command hung");
  endtask

  task automatic chk_mem(input logic [5:0] a, input logic [15:0] e);
    rd_addr <= a;
    repeat (2) @(posedge core_clk);
    check_word(rd_data, e, "stored word");
  endtask

  task automatic chk_idle();
    check_bit(unlocked, 1'b0, "lock flag");
    check_bit(busy, 1'b0, "busy");
    check_bit(ready, 1'b1, "ready");
    check_bit(swe_link_if_inst.sdout_oe, 1'b0, "output enable");
  endtask

  // watchdog
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    conclude();
  end

  // main sequence
  initial begin
    int b0;
    int s0;
    int k0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk_idle();
    chk_mem(6'h2A, 16'hFFFF);
    foreach (rows[i]) begin
      rd_addr <= rows[i].a;
      b0 = busy_n;
      s0 = stat_n;
      k0 = clk_n;
      run_cmd(rows[i].c, rows[i].a, rows[i].d);
      check_cnt(busy_n - b0, rows[i].n, "cycle length");
      check_cnt(clk_n - k0, 0, "clocks in cycle");
      check_bit(stat_n != s0, rows[i].n != 0, "status seen");
      check_bit(unlocked, rows[i].u, "lock flag");
      if (rows[i].c == swe_pkg::CMD_FILL) begin
        for (int j = 0; j < swe_pkg::WORDS; j++) chk_mem(j[5:0], rows[i].e);
      end
      else chk_mem(rows[i].a, rows[i].e);
    end
    // reset in mid-frame, then a write to the locked device
    @(posedge core_clk);
    req <= 1'b1;
    cmd <= swe_pkg::CMD_UNLOCK;
    @(posedge core_clk);
    req <= 1'b0;
    repeat (40) @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk_idle();
    check_bit(swe_link_if_inst.sel, 1'b0, "select in reset");
    rstn <= 1'b1;
    b0 = busy_n;
    run_cmd(swe_pkg::CMD_WRITE, 6'h11, 16'h0000);
    check_cnt(busy_n - b0, 0, "locked write");
    chk_mem(6'h11, 16'hFFFF);
    conclude();
  end
endmodule

`default_nettype wire
